// [hw/i2c_master_stop_arb.sv]
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - buffer write during acknowledge sequence sets write collision flag, buffer kept.
// - stop enable set with SCL low makes master pull SDA low.
// - SDA seen low in stop: reload baud counter, count to zero, release SCL.
// - in stop, SDA released one baud period after SCL released.
// - stop seen flag set when SDA high while SCL high.
// - one baud period after stop, stop enable clears and port interrupt sets.
// - buffer write during stop sequence sets write collision flag, buffer kept.
// - in sleep keep running; wake on completed byte when interrupt enabled.
// - reset disables port and abandons any transfer.
// - start seen and stop seen clear on reset or port disable.
// - bus busy with other traffic: stop on bus raises enabled port interrupt.
// - SDA low while released high with SCL high: collision flag, port idle.
// - collision checked in address, data, start, acknowledge.
// - transmit collision halts shifting, clears full flag, releases lines.
// - sequence collision aborts it, releases lines, clears its enable bits.
// - after lost arbitration keep watching; stop sets port interrupt.
// - after collision new buffer write starts at first data bit.
// - SDA or SCL low at start request: abort, collision flag, idle.
// - start: SDA high loads counter from reload bits; SCL low then collides.
// - SDA low in first start count: reset counter, drive SDA early, no flag.
// - second start count ignores SCL low; SCL driven low at end.
module i2c_master_stop_arb (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_sleep,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic [7:0] o_rdata,
  output logic o_scl_o,
  output logic o_scl_oe,
  output logic o_sda_o,
  output logic o_sda_oe,
  output logic o_wake
);

  i2c_master_pkg::state_t state;
  i2c_master_pkg::bus_req_t req;
  i2c_master_pkg::lines_t s1, s2, s3, ln;
  logic [7:0] tx_rx_buffer;
  logic [7:0] shift;
  logic [6:0] baud_reload_value;
  logic [6:0] baud_counter;
  logic [3:0] bit_cnt;
  logic port_enable;
  logic write_collision_flag;
  logic buffer_full_flag;
  logic port_interrupt_flag;
  logic bus_collision_flag;
  logic irq_enable;
  logic start_seen;
  logic stop_seen;
  logic start_enable, restart_enable, stop_enable, recv_enable, ack_enable, ack_data;
  logic sda_low, scl_low;
  logic prev_sda;
  logic baud_zero;
  logic busy;
  logic wr_buf;
  logic collide;
  logic stop_event;
  logic stop_done;

  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
  assign baud_zero = (baud_counter == 7'h00);
  assign busy = (state != i2c_master_pkg::ST_IDLE);
  assign wr_buf = req.wr && (req.addr == i2c_master_pkg::ADDR_BUFFER);

  // three-stage pin sync; a level change counts once stages two and three agree
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      s1 <= 2'h3;
      s2 <= 2'h3;
      s3 <= 2'h3;
      ln <= 2'h3;
    end
    else
    begin
      s1 <= '{scl: i_scl, sda: i_sda};
      s2 <= s1;
      s3 <= s2;
      if (s2.scl == s3.scl)
        ln.scl <= s3.scl;
      if (s2.sda == s3.sda)
        ln.sda <= s3.sda;
    end
  end

  // bus-level start/stop detection runs whatever the master state is
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
      prev_sda <= 1'b1;
    else
      prev_sda <= ln.sda;
  end
  assign stop_event = port_enable && ln.scl && ln.sda && !prev_sda;

  // start seen / stop seen flags
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst || !port_enable)
    begin
      start_seen <= 1'b0;
      stop_seen <= 1'b0;
    end
    else if (stop_event)
    begin
      stop_seen <= 1'b1;
      start_seen <= 1'b0;
    end
    else if (ln.scl && !ln.sda && prev_sda)
    begin
      start_seen <= 1'b1;
      stop_seen <= 1'b0;
    end
  end

  // arbitration loss: we released SDA but the bus reads low while SCL is high;
  // in the first start count a low SDA is another master's start, not a loss, but a low SCL is
  assign collide = (!sda_low && ln.scl && !ln.sda &&
    (state == i2c_master_pkg::ST_TX_HIGH || state == i2c_master_pkg::ST_ACKSEQ_HIGH)) ||
    (state == i2c_master_pkg::ST_START_A && ln.sda && !ln.scl);

  assign stop_done = (state == i2c_master_pkg::ST_STOP_END) && baud_zero;

  // main sequencer: start, byte transmit, ack, stop
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst || !port_enable)
    begin
      state <= i2c_master_pkg::ST_IDLE;
      sda_low <= 1'b0;
      scl_low <= 1'b0;
      baud_counter <= 7'h00;
      bit_cnt <= 4'h0;
      shift <= i2c_master_pkg::RESET_BYTE;
    end
    else if (collide)
    begin
      state <= i2c_master_pkg::ST_IDLE;
      sda_low <= 1'b0;
      scl_low <= 1'b0;
      bit_cnt <= 4'h0;
    end
    else
    begin
      if (!baud_zero)
        baud_counter <= baud_counter - 7'h01;
      case (state)
        i2c_master_pkg::ST_IDLE:
        begin
          if (start_enable && ln.sda && ln.scl)
          begin
            baud_counter <= baud_reload_value;
            state <= i2c_master_pkg::ST_START_A;
          end
          else if (stop_enable)
          begin
            sda_low <= 1'b1;
            scl_low <= 1'b1;
            state <= i2c_master_pkg::ST_STOP_DRV;
          end
          else if (ack_enable)
          begin
            sda_low <= !ack_data;
            scl_low <= 1'b1;
            baud_counter <= baud_reload_value;
            state <= i2c_master_pkg::ST_ACKSEQ_LOW;
          end
          else if (wr_buf && !buffer_full_flag)
          begin
            shift <= req.wdata;
            bit_cnt <= 4'h0;
            scl_low <= 1'b1;
            sda_low <= !req.wdata[7];
            baud_counter <= baud_reload_value;
            state <= i2c_master_pkg::ST_TX_LOW;
          end
        end
        i2c_master_pkg::ST_START_A:
        begin
          if (!ln.sda)
          begin
            sda_low <= 1'b1;
            baud_counter <= baud_reload_value;
            state <= i2c_master_pkg::ST_START_B;
          end
          else if (baud_zero)
          begin
            sda_low <= 1'b1;
            baud_counter <= baud_reload_value;
            state <= i2c_master_pkg::ST_START_B;
          end
        end
        i2c_master_pkg::ST_START_B:
        begin
          if (baud_zero)
          begin
            scl_low <= 1'b1;
            state <= i2c_master_pkg::ST_IDLE;
          end
        end
        i2c_master_pkg::ST_TX_LOW:
        begin
          if (baud_zero)
          begin
            scl_low <= 1'b0;
            if (ln.scl)
            begin
              baud_counter <= baud_reload_value;
              state <= (bit_cnt == i2c_master_pkg::BIT_COUNT_FULL) ?
                i2c_master_pkg::ST_ACK_HIGH : i2c_master_pkg::ST_TX_HIGH;
            end
          end
        end
        i2c_master_pkg::ST_TX_HIGH:
        begin
          if (baud_zero)
          begin
            scl_low <= 1'b1;
            shift <= {shift[6:0], 1'b0};
            bit_cnt <= bit_cnt + 4'h1;
            sda_low <= (bit_cnt == 4'h7) ? 1'b0 : !shift[6];
            baud_counter <= baud_reload_value;
            state <= i2c_master_pkg::ST_TX_LOW;
          end
        end
        i2c_master_pkg::ST_ACK_HIGH:
        begin
          if (baud_zero)
          begin
            scl_low <= 1'b1;
            state <= i2c_master_pkg::ST_IDLE;
          end
        end
        i2c_master_pkg::ST_ACKSEQ_LOW:
        begin
          if (baud_zero)
          begin
            scl_low <= 1'b0;
            if (ln.scl)
            begin
              baud_counter <= baud_reload_value;
              state <= i2c_master_pkg::ST_ACKSEQ_HIGH;
            end
          end
        end
        i2c_master_pkg::ST_ACKSEQ_HIGH:
        begin
          if (baud_zero)
          begin
            scl_low <= 1'b1;
            state <= i2c_master_pkg::ST_IDLE;
          end
        end
        i2c_master_pkg::ST_STOP_DRV:
        begin
          if (!ln.sda)
          begin
            baud_counter <= baud_reload_value;
            state <= i2c_master_pkg::ST_STOP_SCL;
          end
        end
        i2c_master_pkg::ST_STOP_SCL:
        begin
          if (baud_zero)
          begin
            scl_low <= 1'b0;
            if (ln.scl)
            begin
              baud_counter <= baud_reload_value;
              state <= i2c_master_pkg::ST_STOP_SDA;
            end
          end
        end
        i2c_master_pkg::ST_STOP_SDA:
        begin
          if (baud_zero)
          begin
            sda_low <= 1'b0;
            if (ln.sda && ln.scl)
            begin
              baud_counter <= baud_reload_value;
              state <= i2c_master_pkg::ST_STOP_END;
            end
          end
        end
        i2c_master_pkg::ST_STOP_END:
        begin
          if (baud_zero)
            state <= i2c_master_pkg::ST_IDLE;
        end
        default:
          state <= i2c_master_pkg::ST_IDLE;
      endcase
    end
  end

  // open-drain pins: enable pulls low, output value is always zero
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      o_scl_o <= 1'b0;
      o_sda_o <= 1'b0;
      o_scl_oe <= 1'b0;
      o_sda_oe <= 1'b0;
    end
    else
    begin
      o_scl_o <= 1'b0;
      o_sda_o <= 1'b0;
      o_scl_oe <= scl_low && port_enable && !collide;
      o_sda_oe <= sda_low && port_enable && !collide;
    end
  end

  // software registers; start request with lines already low is a collision
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      port_enable <= 1'b0;
      baud_reload_value <= i2c_master_pkg::RESET_RELOAD;
      irq_enable <= 1'b0;
      {start_enable, restart_enable, stop_enable, recv_enable, ack_enable, ack_data} <= 6'h00;
    end
    else
    begin
      if (req.wr && req.addr == i2c_master_pkg::ADDR_RELOAD)
        baud_reload_value <= req.wdata[6:0];
      if (req.wr && req.addr == i2c_master_pkg::ADDR_CTL1)
        port_enable <= req.wdata[i2c_master_pkg::CTL1_ENABLE_BIT];
      if (req.wr && req.addr == i2c_master_pkg::ADDR_FLAGS)
        irq_enable <= req.wdata[i2c_master_pkg::FLAG_IRQ_EN_BIT];
      if (req.wr && req.addr == i2c_master_pkg::ADDR_CTL2 && !busy)
      begin
        start_enable <= req.wdata[i2c_master_pkg::CTL_START_BIT];
        restart_enable <= req.wdata[i2c_master_pkg::CTL_RESTART_BIT];
        stop_enable <= req.wdata[i2c_master_pkg::CTL_STOP_BIT];
        recv_enable <= req.wdata[i2c_master_pkg::CTL_RECV_BIT];
        ack_enable <= req.wdata[i2c_master_pkg::CTL_ACK_BIT];
        ack_data <= req.wdata[i2c_master_pkg::CTL_ACKDATA_BIT];
      end
      else if (collide || !port_enable || (!busy && start_enable && (!ln.sda || !ln.scl)))
        {start_enable, restart_enable, stop_enable, recv_enable, ack_enable} <= 5'h00;
      else
      begin
        if (state == i2c_master_pkg::ST_START_B && baud_zero)
          start_enable <= 1'b0;
        if (stop_done)
          stop_enable <= 1'b0;
        if (state == i2c_master_pkg::ST_ACKSEQ_HIGH && baud_zero)
          ack_enable <= 1'b0;
      end
    end
  end

  // buffer, full flag and write collision flag; set wins over software clear
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      tx_rx_buffer <= i2c_master_pkg::RESET_BYTE;
      buffer_full_flag <= 1'b0;
      write_collision_flag <= 1'b0;
    end
    else
    begin
      if (wr_buf && (busy || buffer_full_flag))
        write_collision_flag <= 1'b1;
      else if (req.wr && req.addr == i2c_master_pkg::ADDR_CTL1 &&
               !req.wdata[i2c_master_pkg::CTL1_WRITE_COLLISION_FLAG_BIT])
        write_collision_flag <= 1'b0;
      if (wr_buf && !busy && !buffer_full_flag && port_enable)
      begin
        tx_rx_buffer <= req.wdata;
        buffer_full_flag <= 1'b1;
      end
      else if (collide || (state == i2c_master_pkg::ST_TX_HIGH && bit_cnt == 4'h7 && baud_zero))
        buffer_full_flag <= 1'b0;
    end
  end

  // port interrupt and bus collision flags; hardware set beats software clear
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      port_interrupt_flag <= 1'b0;
      bus_collision_flag <= 1'b0;
    end
    else
    begin
      if (stop_done || (stop_event && !busy) ||
          (state == i2c_master_pkg::ST_ACK_HIGH && baud_zero) ||
          (state == i2c_master_pkg::ST_START_B && baud_zero))
        port_interrupt_flag <= 1'b1;
      else if (req.wr && req.addr == i2c_master_pkg::ADDR_FLAGS &&
               !req.wdata[i2c_master_pkg::FLAG_PORT_IRQ_BIT])
        port_interrupt_flag <= 1'b0;
      if (collide || (port_enable && !busy && start_enable && (!ln.sda || !ln.scl)))
        bus_collision_flag <= 1'b1;
      else if (req.wr && req.addr == i2c_master_pkg::ADDR_FLAGS &&
               !req.wdata[i2c_master_pkg::FLAG_COLL_BIT])
        bus_collision_flag <= 1'b0;
    end
  end

  // wake only while sleeping with the interrupt enabled
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
      o_wake <= 1'b0;
    else
      o_wake <= i_sleep && irq_enable && port_interrupt_flag;
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst || !req.rd)
      o_rdata <= 8'h00;
    else
      case (req.addr)
        i2c_master_pkg::ADDR_BUFFER: o_rdata <= tx_rx_buffer;
        i2c_master_pkg::ADDR_RELOAD: o_rdata <= {1'b0, baud_reload_value};
        i2c_master_pkg::ADDR_CTL1: o_rdata <= {write_collision_flag, 1'b0, port_enable, 5'h00};
        i2c_master_pkg::ADDR_CTL2: o_rdata <= {2'h0, ack_data, ack_enable, recv_enable,
                                               stop_enable, restart_enable, start_enable};
        i2c_master_pkg::ADDR_STATUS: o_rdata <= {3'h0, stop_seen, start_seen, 2'h0,
                                                 buffer_full_flag};
        i2c_master_pkg::ADDR_FLAGS: o_rdata <= {5'h00, irq_enable, bus_collision_flag,
                                                port_interrupt_flag};
        default: o_rdata <= 8'h00;
      endcase
  end

endmodule : i2c_master_stop_arb

`default_nettype wire

// [hw/i2c_master_pkg.sv]
package i2c_master_pkg;

  // control register 2 bit positions
  localparam int CTL_START_BIT = 0;
  localparam int CTL_RESTART_BIT = 1;
  localparam int CTL_STOP_BIT = 2;
  localparam int CTL_RECV_BIT = 3;
  localparam int CTL_ACK_BIT = 4;
  localparam int CTL_ACKDATA_BIT = 5;

  // status register bit positions
  localparam int STAT_FULL_BIT = 0;
  localparam int STAT_START_SEEN_BIT = 3;
  localparam int STAT_STOP_SEEN_BIT = 4;

  // control register 1 bit positions
  localparam int CTL1_ENABLE_BIT = 5;
  localparam int CTL1_WRITE_COLLISION_FLAG_BIT = 7;

  // register offsets
  localparam logic [2:0] ADDR_BUFFER = 3'h0;
  localparam logic [2:0] ADDR_RELOAD = 3'h1;
  localparam logic [2:0] ADDR_CTL1 = 3'h2;
  localparam logic [2:0] ADDR_CTL2 = 3'h3;
  localparam logic [2:0] ADDR_STATUS = 3'h4;
  localparam logic [2:0] ADDR_FLAGS = 3'h5;

  // flag register bits
  localparam int FLAG_PORT_IRQ_BIT = 0;
  localparam int FLAG_COLL_BIT = 1;
  localparam int FLAG_IRQ_EN_BIT = 2;

  // reset values and full bit count
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [6:0] RESET_RELOAD = 7'h00;
  localparam logic [3:0] BIT_COUNT_FULL = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_START_A = 4'b0001,
    ST_START_B = 4'b0010,
    ST_TX_LOW = 4'b0011,
    ST_TX_HIGH = 4'b0100,
    ST_ACK_LOW = 4'b0101,
    ST_ACK_HIGH = 4'b0110,
    ST_STOP_DRV = 4'b0111,
    ST_STOP_SCL = 4'b1000,
    ST_STOP_SDA = 4'b1001,
    ST_STOP_END = 4'b1010,
    ST_ACKSEQ_LOW = 4'b1011,
    ST_ACKSEQ_HIGH = 4'b1100
  } state_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } lines_t;

endpackage : i2c_master_pkg

// [bench/i2c_master_stop_arb_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
// pin-level checks; register state is judged by the bench
module i2c_master_stop_arb_asserts (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_rd,
  input wire logic i_sleep,
  input wire logic [7:0] o_rdata,
  input wire logic o_scl_o,
  input wire logic o_scl_oe,
  input wire logic o_sda_o,
  input wire logic o_sda_oe,
  input wire logic o_wake
);
  default clocking cb @(posedge i_sys_clk);
  endclocking

  // a driven high would fight the other masters on the wired-and bus
  chk_scl_never_high: assert property (o_scl_o == 1'b0)
    else $error("scl output data driven high");
  chk_sda_never_high: assert property (o_sda_o == 1'b0)
    else $error("sda output data driven high");
  // reset must drop the bus and every output
  chk_reset_lines: assert property (i_rst |=> !o_scl_oe && !o_sda_oe)
    else $error("line still pulled after reset");
  chk_reset_wake: assert property (i_rst |=> !o_wake)
    else $error("wake still high after reset");
  chk_reset_rdata: assert property (i_rst |=> o_rdata == 8'h00)
    else $error("read data not cleared by reset");
  // read data stand only in the cycle after the read strobe
  chk_rdata_idle: assert property (disable iff (i_rst) !$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read answer cycle");
  chk_wake_asleep: assert property (disable iff (i_rst) o_wake |-> $past(i_sleep))
    else $error("wake raised while awake");
  // sda let go with scl up is a stop: scl must have been up for a while
  chk_stop_order: assert property (disable iff (i_rst)
    $fell(o_sda_oe) && !o_scl_oe |-> !$past(o_scl_oe) && !$past(o_scl_oe, 2))
    else $error("sda released too soon after scl in stop");
endmodule : i2c_master_stop_arb_asserts
`default_nettype wire

// [bench/i2c_far_side.sv]
`timescale 1ns/1ps
`default_nettype none
// other master on the bus; it only pulls lines low, the pull-ups do the rest
module i2c_far_side (
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_low,
  output logic o_sda_low
);
  initial
  begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
  end

  task automatic set_sda(input logic v);
    o_sda_low <= v;
  endtask : set_sda

  task automatic set_scl(input logic v);
    o_scl_low <= v;
  endtask : set_scl

  // start, one clock, stop at the 80 ns link rate; offset keeps off sys edges
  task automatic frame;
    wait (i_scl && i_sda);
    #3 o_sda_low = 1'b1;
    #40 o_scl_low = 1'b1;
    #40 o_scl_low = 1'b0;
    #40 o_sda_low = 1'b0;
  endtask : frame
endmodule : i2c_far_side
`default_nettype wire

// [bench/i2c_master_stop_and_arbitration_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module i2c_master_stop_and_arbitration_bench;
  localparam logic [2:0] A_BUF = i2c_master_pkg::ADDR_BUFFER;
  localparam logic [2:0] A_RLD = i2c_master_pkg::ADDR_RELOAD;
  localparam logic [2:0] A_C1 = i2c_master_pkg::ADDR_CTL1;
  localparam logic [2:0] A_C2 = i2c_master_pkg::ADDR_CTL2;
  localparam logic [2:0] A_ST = i2c_master_pkg::ADDR_STATUS;
  localparam logic [2:0] A_FL = i2c_master_pkg::ADDR_FLAGS;
  localparam int IRQ = i2c_master_pkg::FLAG_PORT_IRQ_BIT;
  localparam int COL = i2c_master_pkg::FLAG_COLL_BIT;
  localparam int SP = i2c_master_pkg::STAT_STOP_SEEN_BIT;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_sleep = 1'b0;
  i2c_master_pkg::bus_req_t req = '0;
  logic [7:0] o_rdata;
  logic o_scl_o;
  logic o_scl_oe;
  logic o_sda_o;
  logic o_sda_oe;
  logic o_wake;
  logic far_scl_low;
  logic far_sda_low;
  logic [7:0] d;
  int failures = 0;
  int checks_done = 0;

  always #4 i_sys_clk = ~i_sys_clk;

  // wired-and bus with pull-ups
  wire scl_line = ~(o_scl_oe | far_scl_low);
  wire sda_line = ~(o_sda_oe | far_sda_low);

  i2c_master_stop_arb uut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(req.addr), .i_wdata(req.wdata),
    .i_wr(req.wr), .i_rd(req.rd), .i_sleep(i_sleep), .i_scl(scl_line), .i_sda(sda_line), .o_rdata(o_rdata),
    .o_scl_o(o_scl_o), .o_scl_oe(o_scl_oe), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .o_wake(o_wake));

  i2c_far_side far (.i_scl(scl_line), .i_sda(sda_line), .o_scl_low(far_scl_low), .o_sda_low(far_sda_low));

  task automatic print_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // bus cycles: one strobe cycle, then an idle cycle so strobes never merge
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    req <= '{a, v, 1'b1, 1'b0};
    @(posedge i_sys_clk);
    req <= '0;
    @(posedge i_sys_clk);
  endtask : wr

  task automatic rd(input logic [2:0] a);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge i_sys_clk);
    req <= '0;
    #1 d = o_rdata;
    @(posedge i_sys_clk);
  endtask : rd

  task automatic rdbit(input string what, input logic [2:0] a, input int b, input logic v);
    rd(a);
    check(what, 8'(d[b]), 8'(v));
  endtask : rdbit

  // polling is bounded so a stuck flag shows as a mismatch, not a hang
  task automatic poll(input string what, input logic [2:0] a, input int b, input logic v);
    int n;
    for (n = 0; n < 300; n++)
    begin
      rd(a);
      if (d[b] === v)
        break;
    end
    check(what, 8'(d[b]), 8'(v));
  endtask : poll

  function automatic logic pin(input int k);
    case (k)
      0: return o_sda_oe;
      1: return o_scl_oe;
      default: return o_wake;
    endcase
  endfunction : pin

  task automatic await(input string what, input int k, input logic v);
    int n;
    for (n = 0; n < 400; n++)
    begin
      if (pin(k) === v)
        break;
      @(posedge i_sys_clk);
    end
    check(what, 8'(pin(k)), 8'(v));
  endtask : await

  // start, one byte, ack clock; the byte is read back off the wire msb first
  task automatic xfer(input logic [7:0] v);
    logic [7:0] b;
    int i;
    wr(A_C2, 8'h01);
    poll("start done", A_FL, IRQ, 1'b1);
    check("start holds lines", {6'h00, o_scl_oe, o_sda_oe}, 8'h03);
    wr(A_FL, 8'h00);
    wr(A_BUF, v);
    for (i = 0; i < 8; i++)
    begin
      @(posedge scl_line);
      b = {b[6:0], sda_line};
    end
    check("wire byte", b, v);
    poll("byte done", A_FL, IRQ, 1'b1);
    wr(A_FL, 8'h00);
  endtask : xfer

  task automatic stop_seq;
    wr(A_C2, 8'h04);
    poll("stop done", A_FL, IRQ, 1'b1);
    wr(A_FL, 8'h00);
  endtask : stop_seq

  task automatic t_regs;
    int a;
    for (a = 0; a < 6; a++)
    begin
      rd(3'(a));
      check("reset value", d, 8'h00);
    end
    wr(3'h7, 8'hFF);
    rd(3'h7);
    check("unmapped", d, 8'h00);
    wr(A_RLD, 8'h05);
    wr(A_C1, 8'h20);
    rd(A_RLD);
    check("reload", d, 8'h05);
  endtask : t_regs

  // another master holds sda low under our first 1 bit
  task automatic t_lost;
    wr(A_C2, 8'h01);
    poll("start done", A_FL, IRQ, 1'b1);
    wr(A_FL, 8'h00);
    far.set_sda(1'b1);
    wr(A_BUF, 8'hFF);
    poll("collision", A_FL, COL, 1'b1);
    rdbit("full cleared", A_ST, i2c_master_pkg::STAT_FULL_BIT, 1'b0);
    check("lines released", {6'h00, o_scl_oe, o_sda_oe}, 8'h00);
    far.set_sda(1'b0);
    poll("stop seen after loss", A_ST, SP, 1'b1);
    poll("irq after loss", A_FL, IRQ, 1'b1);
    wr(A_FL, 8'h00);
    xfer(8'hC3);
    stop_seq();
  endtask : t_lost

  // another master starts first: our start pulls sda early with no collision
  task automatic t_start_early;
    far.set_sda(1'b1);
    wr(A_C2, 8'h01);
    poll("early start done", A_FL, IRQ, 1'b1);
    rdbit("early start no collision", A_FL, COL, 1'b0);
    far.set_sda(1'b0);
    wr(A_FL, 8'h00);
    stop_seq();
  endtask : t_start_early

  // lines pass the pin synchroniser before the start request is looked at
  task automatic t_start_busy;
    far.set_scl(1'b1);
    repeat (4) @(posedge i_sys_clk);
    wr(A_C2, 8'h01);
    poll("start collision", A_FL, COL, 1'b1);
    check("sda not pulled", 8'(o_sda_oe), 8'h00);
    rdbit("start bit cleared", A_C2, i2c_master_pkg::CTL_START_BIT, 1'b0);
    far.set_scl(1'b0);
    repeat (4) @(posedge i_sys_clk);
    wr(A_FL, 8'h00);
  endtask : t_start_busy

  // buffer writes refused during ack and stop sequences
  task automatic t_stop;
    xfer(8'hA5);
    wr(A_C2, 8'h30); // not-acknowledge leaves sda free, so the stop must pull it
    wr(A_BUF, 8'h5A);
    rdbit("ack write_collision_flag", A_C1, i2c_master_pkg::CTL1_WRITE_COLLISION_FLAG_BIT, 1'b1);
    poll("ack ends", A_C2, i2c_master_pkg::CTL_ACK_BIT, 1'b0);
    wr(A_C1, 8'h20);
    wr(A_FL, 8'h00);
    wr(A_C2, 8'h04);
    await("stop pulls sda", 0, 1'b1);
    check("scl held low", 8'(o_scl_oe), 8'h01);
    wr(A_BUF, 8'h3C);
    await("stop frees scl", 1, 1'b0);
    poll("stop seen", A_ST, SP, 1'b1);
    poll("stop irq", A_FL, IRQ, 1'b1);
    rdbit("stop bit cleared", A_C2, i2c_master_pkg::CTL_STOP_BIT, 1'b0);
    rdbit("stop write_collision_flag", A_C1, i2c_master_pkg::CTL1_WRITE_COLLISION_FLAG_BIT, 1'b1);
    rd(A_BUF);
    check("buffer kept", d, 8'hA5);
    wr(A_C1, 8'h20);
    wr(A_FL, 8'h00);
  endtask : t_stop

  task automatic t_reset_mid;
    wr(A_C2, 8'h01);
    poll("start done", A_FL, IRQ, 1'b1);
    wr(A_BUF, 8'h96);
    repeat (20) @(posedge i_sys_clk);
    i_rst <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    check("lines after reset", {6'h00, o_scl_oe, o_sda_oe}, 8'h00);
    rd(A_C1);
    check("port disabled", d, 8'h00);
    rd(A_ST);
    check("status after reset", d, 8'h00);
    wr(A_RLD, 8'h05);
    wr(A_C1, 8'h20);
  endtask : t_reset_mid

  // another master's frame wakes a sleeping port; disable clears stop seen
  task automatic t_sleep;
    wr(A_FL, 8'h04);
    i_sleep <= 1'b1;
    @(posedge i_sys_clk);
    far.frame();
    await("wake", 2, 1'b1);
    i_sleep <= 1'b0;
    @(posedge i_sys_clk);
    rdbit("bus stop irq", A_FL, IRQ, 1'b1);
    rdbit("stop seen", A_ST, SP, 1'b1);
    wr(A_C1, 8'h00);
    rdbit("stop seen cleared", A_ST, SP, 1'b0);
  endtask : t_sleep

  initial
  begin
    repeat (12) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    @(posedge i_sys_clk);
    t_regs();
    t_lost();
    t_start_early();
    t_start_busy();
    t_stop();
    t_reset_mid();
    t_sleep();
    print_verdict();
  end

  // the whole run needs a few thousand cycles; 50000 means a hang
  initial
  begin
    #400000;
    failures++;
    print_verdict();
  end
endmodule : i2c_master_stop_and_arbitration_bench

bind i2c_master_stop_arb i2c_master_stop_arb_asserts chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_rd(i_rd),
  .i_sleep(i_sleep), .o_rdata(o_rdata), .o_scl_o(o_scl_o), .o_scl_oe(o_scl_oe), .o_sda_o(o_sda_o),
  .o_sda_oe(o_sda_oe), .o_wake(o_wake));
`default_nettype wire
